// *** shared/supervision_timer_regs.svh ***
// register map, field layout and timing constants of the board watchdog
`ifndef SUPERVISION_TIMER_REGS_SVH
`define SUPERVISION_TIMER_REGS_SVH

`define CTRL_ADDR 32'h2380_0000
`define SERVICE_ADDR 32'h23C0_0000
`define ADDR_DECODE_MASK 32'hFFFF_FFFC
`define CODE_WIDTH 3
`define CODE_RESET 3'h0
`define SERVICE_WIDTH 8
`define SERVICE_KEY 8'h05
`define CLK_HZ 25000000
`define TICK_MS 1
`define TICK_CYCLES (`CLK_HZ / 1000 * `TICK_MS)
`define WINDOW_NS 30000
`define CLK_PERIOD_NS 40
`define WINDOW_CYCLES (`WINDOW_NS / `CLK_PERIOD_NS)
`define PERIOD_250_MS 250
`define PERIOD_500_MS 500
`define PERIOD_1_S 1000
`define PERIOD_2_S 2000
`define PERIOD_4_S 4000
`define PERIOD_8_S 8000
`define RESET_PULSE_CYCLES 16

`endif

// *** shared/supervision_timer_pkg.sv ***
// types shared by the board watchdog files
package supervision_timer_pkg;
    typedef logic [2:0] timeout_code_t;
    typedef enum logic [2:0] {
        CODE_OFF,
        CODE_250MS,
        CODE_500MS,
        CODE_1S,
        CODE_RSVD,
        CODE_2S,
        CODE_4S,
        CODE_8S
    } code_name_t;
    typedef enum {
        WD_IDLE,
        WD_RUN,
        WD_FIRE
    } wd_state_t;
endpackage

// *** hdl/service_window.sv ***
// control-write acceptance window opened by a valid service write
`timescale 1ns/100ps
`include "supervision_timer_regs.svh"
module service_window
    import supervision_timer_pkg::*;
#(
    parameter int WINDOW_CYCLES = `WINDOW_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // events
    input wire logic feedValid,
    input wire logic ctrlWrite,
    // status
    output logic windowOpen
);
    logic [15:0] windowCount;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            windowCount <= 16'h0000;
        end else if (feedValid) begin
            windowCount <= 16'(WINDOW_CYCLES); // RULE_05
        end else if (ctrlWrite) begin
            windowCount <= 16'h0000;
        end else if (windowCount != 16'h0000) begin
            windowCount <= windowCount - 16'h0001;
        end
    end

    assign windowOpen = (windowCount != 16'h0000);

    chk_window_length: assert property (@(posedge ref_clk) disable iff (srst) // RULE_05
        feedValid ##1 (!feedValid && !ctrlWrite) [*8] |-> windowOpen)
        else $error("window closed too early after feed");
endmodule

// *** hdl/timeout_decoder.sv ***
// maps a timeout code to a period in millisecond ticks
`timescale 1ns/100ps
`include "supervision_timer_regs.svh"
module timeout_decoder
    import supervision_timer_pkg::*;
(
    // code in
    input wire logic [2:0] code,
    // period out
    output logic [13:0] periodTicks,
    output logic enabled
);
    function automatic logic [13:0] period_of(input logic [2:0] c);
        case (c)
            CODE_250MS: period_of = 14'(`PERIOD_250_MS); // RULE_01
            CODE_500MS: period_of = 14'(`PERIOD_500_MS);
            CODE_1S: period_of = 14'(`PERIOD_1_S);
            CODE_2S: period_of = 14'(`PERIOD_2_S);
            CODE_4S: period_of = 14'(`PERIOD_4_S);
            CODE_8S: period_of = 14'(`PERIOD_8_S);
            default: period_of = 14'h0000;
        endcase
    endfunction

    // reserved and off codes both leave supervision idle
    assign periodTicks = period_of(code);
    assign enabled = (periodTicks != 14'h0000);
endmodule

// *** hdl/board_watchdog_timer.sv ***
// board watchdog: AHB-Lite slave, timeout control, service key, system reset
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
//
// Overview of operation
// RULE_01 - code selects off, period, or reserved
// RULE_02 - nonzero code starts counter advancing; reserved code 4 leaves it idle
// RULE_03 - counter reaching period asserts system reset
// RULE_04 - writing 05 to service clears counter
// RULE_05 - control write accepted within 30us of feed
// RULE_06 - unfed control write keeps stored code
// RULE_07 - software feeds before timeout expires
// RULE_08 - software feeds then loads control code
// RULE_09 - other service values do nothing
`include "supervision_timer_regs.svh"
module board_watchdog_timer
    import supervision_timer_pkg::*;
#(
    parameter int TICK_CYCLES = `TICK_CYCLES,
    parameter int WINDOW_CYCLES = `WINDOW_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // system
    output logic systemReset
);
    logic dataWrite;
    logic [31:0] dataAddr;
    logic ctrlWrite;
    logic serviceWrite;
    logic feedValid;
    logic windowOpen;
    timeout_code_t timeoutCode;
    logic [13:0] periodTicks;
    logic enabled;
    logic [24:0] tickCount;
    logic tick;
    logic [13:0] elapsed;
    wd_state_t state;
    logic [4:0] pulseCount;
    logic readPending;

    // address phase capture
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            dataWrite <= 1'b0;
            readPending <= 1'b0;
            dataAddr <= 32'h0000_0000;
        end else if (hready) begin
            dataWrite <= hsel && htrans[1] && hwrite;
            readPending <= hsel && htrans[1] && !hwrite;
            dataAddr <= haddr & `ADDR_DECODE_MASK;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign ctrlWrite = dataWrite && (dataAddr == `CTRL_ADDR);
    assign serviceWrite = dataWrite && (dataAddr == `SERVICE_ADDR);
    assign feedValid = serviceWrite && (hwdata[7:0] == `SERVICE_KEY); // RULE_04 RULE_09

    // read data: control word readable, service reads zero
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite &&
                     ((haddr & `ADDR_DECODE_MASK) == `CTRL_ADDR)) begin
            hrdata <= {29'h0000_0000, timeoutCode};
        end else begin
            hrdata <= 32'h0000_0000;
        end
    end

    service_window #(
        .WINDOW_CYCLES(WINDOW_CYCLES)
    ) u_window (
        .ref_clk(ref_clk),
        .srst(srst),
        .feedValid(feedValid),
        .ctrlWrite(ctrlWrite),
        .windowOpen(windowOpen)
    );

    // control code store
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            timeoutCode <= `CODE_RESET;
        end else if (ctrlWrite && windowOpen) begin
            timeoutCode <= hwdata[2:0]; // RULE_05 RULE_06
        end
    end

    timeout_decoder u_decode (
        .code(timeoutCode),
        .periodTicks(periodTicks),
        .enabled(enabled)
    );

    // millisecond tick prescaler
    always_ff @(posedge ref_clk) begin
        if (srst || !enabled || feedValid) begin
            tickCount <= 25'h000_0000;
        end else if (tickCount == 25'(TICK_CYCLES - 1)) begin
            tickCount <= 25'h000_0000;
        end else begin
            tickCount <= tickCount + 25'h000_0001;
        end
    end

    assign tick = enabled && !feedValid && (tickCount == 25'(TICK_CYCLES - 1));

    // supervision state
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state <= WD_IDLE;
            elapsed <= 14'h0000;
            pulseCount <= 5'h00;
        end else begin
            case (state)
                WD_IDLE: begin
                    elapsed <= 14'h0000;
                    if (enabled) begin
                        state <= WD_RUN; // RULE_02
                    end
                end
                WD_RUN: begin
                    if (!enabled) begin
                        state <= WD_IDLE;
                        elapsed <= 14'h0000;
                    end else if (feedValid) begin
                        elapsed <= 14'h0000; // RULE_04
                    end else if (tick) begin
                        if (elapsed + 14'h0001 >= periodTicks) begin
                            state <= WD_FIRE; // RULE_03
                            pulseCount <= 5'(`RESET_PULSE_CYCLES);
                        end
                        elapsed <= elapsed + 14'h0001; // RULE_02
                    end
                end
                WD_FIRE: begin
                    if (pulseCount == 5'h01) begin
                        state <= WD_IDLE;
                    end
                    pulseCount <= pulseCount - 5'h01;
                end
                default: begin
                    state <= WD_IDLE;
                end
            endcase
        end
    end

    assign systemReset = (state == WD_FIRE); // RULE_03

    // checking aids: timeout condition and length of the running reset pulse
    logic timeoutHit;
    logic [4:0] pulseSeen;

    assign timeoutHit = (state == WD_RUN) && enabled && !feedValid && tick &&
                        (elapsed + 14'h0001 >= periodTicks);

    always_ff @(posedge ref_clk) begin
        if (srst || !systemReset) begin
            pulseSeen <= 5'h00;
        end else begin
            pulseSeen <= pulseSeen + 5'h01;
        end
    end

    sequence feed_s;
        feedValid;
    endsequence

    sequence unfed_ctrl_s;
        ctrlWrite && !windowOpen;
    endsequence

    sequence fire_s;
        timeoutHit;
    endsequence

    sequence feed_then_ctrl_s;
        feed_s ##1 !ctrlWrite ##1 ctrlWrite;
    endsequence

    chk_feed_clears: assert property (@(posedge ref_clk) disable iff (srst) // RULE_04
        (feed_s and (state == WD_RUN && enabled)) |=> elapsed == 14'h0000)
        else $error("feed did not clear counter");

    chk_bad_key: assert property (@(posedge ref_clk) disable iff (srst) // RULE_09
        serviceWrite && hwdata[7:0] != `SERVICE_KEY && !windowOpen && !ctrlWrite
        |=> !windowOpen)
        else $error("wrong key opened window");

    chk_unfed_ignored: assert property (@(posedge ref_clk) disable iff (srst) // RULE_06
        unfed_ctrl_s |=> $stable(timeoutCode))
        else $error("unfed control write changed code");

    chk_fed_loads: assert property (@(posedge ref_clk) disable iff (srst) // RULE_05
        ctrlWrite && windowOpen |=> timeoutCode == $past(hwdata[2:0]))
        else $error("fed control write not stored");

    chk_start_run: assert property (@(posedge ref_clk) disable iff (srst) // RULE_02
        state == WD_IDLE && enabled |=> state == WD_RUN)
        else $error("enabled watchdog did not start");

    chk_fire_reset: assert property (@(posedge ref_clk) disable iff (srst) // RULE_03
        fire_s |=> systemReset [*8])
        else $error("timeout did not hold system reset");

    chk_decode_8s: assert property (@(posedge ref_clk) disable iff (srst) // RULE_01
        timeoutCode == 3'h7 |-> periodTicks == 14'(`PERIOD_8_S))
        else $error("8 s code decoded wrongly");

    chk_off_idle: assert property (@(posedge ref_clk) disable iff (srst) // RULE_01
        (timeoutCode == 3'h0 || timeoutCode == 3'h4) && state != WD_FIRE |=> !systemReset)
        else $error("disabled code still supervising");

    // window and service checks
    chk_feed_load: assert property (@(posedge ref_clk) disable iff (srst) // RULE_05
        feed_then_ctrl_s |-> windowOpen)
        else $error("control write right after feed refused");

    chk_window_closes: assert property (@(posedge ref_clk) disable iff (srst) // RULE_06
        ctrlWrite |=> !windowOpen)
        else $error("window stayed open after control write");

    chk_feed_opens: assert property (@(posedge ref_clk) disable iff (srst) // RULE_05
        feed_s |=> windowOpen)
        else $error("valid feed did not open window");

    chk_service_keeps: assert property (@(posedge ref_clk) disable iff (srst) // RULE_09
        serviceWrite |=> $stable(timeoutCode))
        else $error("service write changed code");

    chk_bad_key_run: assert property (@(posedge ref_clk) disable iff (srst) // RULE_09
        serviceWrite && hwdata[7:0] != `SERVICE_KEY && state == WD_RUN && enabled && !tick
        |=> $stable(elapsed))
        else $error("wrong key touched counter");

    // counter and reset pulse checks
    chk_no_early_fire: assert property (@(posedge ref_clk) disable iff (srst) // RULE_03
        state != WD_FIRE && !timeoutHit |=> state != WD_FIRE)
        else $error("system reset without timeout");

    chk_rise_cause: assert property (@(posedge ref_clk) disable iff (srst) // RULE_03
        $rose(systemReset) |-> $past(timeoutHit))
        else $error("system reset rose without timeout");

    chk_disabled_idle: assert property (@(posedge ref_clk) disable iff (srst) // RULE_02
        !enabled && state != WD_FIRE |=> state == WD_IDLE)
        else $error("disabled watchdog left idle");

    chk_idle_cleared: assert property (@(posedge ref_clk) disable iff (srst) // RULE_02
        state == WD_IDLE |=> elapsed == 14'h0000)
        else $error("idle counter not cleared");

    chk_hold_between: assert property (@(posedge ref_clk) disable iff (srst) // RULE_02
        state == WD_RUN && enabled && !feedValid && !tick |=> $stable(elapsed))
        else $error("counter moved without tick");

    chk_tick_advance: assert property (@(posedge ref_clk) disable iff (srst) // RULE_02
        state == WD_RUN && enabled && !feedValid && tick && !timeoutHit
        |=> elapsed == $past(elapsed) + 14'h0001)
        else $error("counter did not advance on tick");

    chk_prescale_bound: assert property (@(posedge ref_clk) disable iff (srst) // RULE_02
        tickCount < 25'(TICK_CYCLES))
        else $error("tick prescaler overran");

    chk_pulse_bounded: assert property (@(posedge ref_clk) disable iff (srst) // RULE_03
        systemReset |-> pulseSeen < 5'(`RESET_PULSE_CYCLES))
        else $error("system reset held too long");

    chk_pulse_full: assert property (@(posedge ref_clk) disable iff (srst) // RULE_03
        $fell(systemReset) && !$past(srst)
        |-> $past(pulseSeen) == 5'(`RESET_PULSE_CYCLES - 1))
        else $error("system reset pulse cut short");

    chk_fire_restart: assert property (@(posedge ref_clk) disable iff (srst) // RULE_02
        $fell(systemReset) && enabled |=> state == WD_RUN)
        else $error("supervision did not restart after pulse");

    // bus and read data checks
    chk_bus_okay: assert property (@(posedge ref_clk) disable iff (srst) // RULE_06
        hreadyout && !hresp)
        else $error("slave stalled or flagged error");

    chk_read_code: assert property (@(posedge ref_clk) disable iff (srst) // RULE_01
        readPending && dataAddr == `CTRL_ADDR
        |-> hrdata == {29'h0000_0000, $past(timeoutCode)})
        else $error("control read returned wrong code");

    chk_read_quiet: assert property (@(posedge ref_clk) disable iff (srst) // RULE_01
        !(readPending && dataAddr == `CTRL_ADDR) |-> hrdata == 32'h0000_0000)
        else $error("read data outside a control read");
endmodule

// *** sim/board_watchdog_timer_bench.sv ***
// self-checking bench for the board watchdog
`timescale 1ns/100ps
`include "supervision_timer_regs.svh"
module board_watchdog_timer_bench;
    import supervision_timer_pkg::*;
    localparam int TICK = 10;
    localparam int WIN = 20;
    localparam int P1 = `PERIOD_250_MS * TICK;
    logic ref_clk;
    logic srst;
    logic hsel;
    logic hwrite;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic systemReset;
    logic rdPhase;
    logic [31:0] expQ[$];
    int num_errors;
    int tests_run;
    int n;
    integer seed;

    board_watchdog_timer #(.TICK_CYCLES(TICK), .WINDOW_CYCLES(WIN)) i_dut (
        .ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .systemReset(systemReset)
    );

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic check(string what, logic [31:0] seen, logic [31:0] expv);
        tests_run++;
        if (seen !== expv) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, expv, seen);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // read data phase follows each sampled read address phase
    always @(posedge ref_clk) begin
        if (rdPhase === 1'b1 && hreadyout === 1'b1) begin
            check("read data", hrdata, expQ.pop_front());
            check("response", {31'h0, hresp}, 32'h0);
        end
        if (hreadyout === 1'b1) begin
            rdPhase <= hsel & htrans[1] & ~hwrite;
        end
    end

    task automatic xfer(logic [31:0] a, logic wr, logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
    endtask

    // unused upper bits carry random noise
    task automatic wr(logic [31:0] a, logic [31:0] d);
        logic [31:0] r;
        r = $random(seed);
        r = r & ((a == `SERVICE_ADDR) ? 32'hFFFF_FF00 : 32'hFFFF_FFF8);
        xfer(a, 1'b1, d | r);
    endtask

    task automatic rd(logic [31:0] a, logic [31:0] e);
        expQ.push_back(e);
        xfer(a, 1'b0, $random(seed));
    endtask

    task automatic feed(logic [7:0] key);
        wr(`SERVICE_ADDR, {24'h0, key});
    endtask

    task automatic waitFire(int limit);
        n = 0;
        while (systemReset !== 1'b1 && n < limit) begin
            @(negedge ref_clk);
            n++;
        end
    endtask

    task automatic fireIn(int lo, int hi);
        waitFire(hi + 50);
        check("fire delay", 32'(n >= lo && n <= hi), 32'h1);
        n = 0;
        while (systemReset === 1'b1 && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        check("pulse width", n, `RESET_PULSE_CYCLES);
    endtask

    initial begin
        repeat (40000) @(posedge ref_clk);
        $display("watchdog expired");
        num_errors++;
        results();
    end

    initial begin
        seed = 32'h6B16;
        srst = 1'b1;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        num_errors = 0;
        tests_run = 0;
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        rd(`CTRL_ADDR, 32'h0);
        rd(`CTRL_ADDR + 32'h10, 32'h0);
        check("reset idle", {31'h0, systemReset}, 32'h0);
        $display("test reset done");
        for (int c = 0; c < 8; c++) begin
            feed(8'h05);
            wr(`CTRL_ADDR, 32'(c));
            rd(`CTRL_ADDR, 32'(c));
        end
        $display("test codes done");
        wr(`CTRL_ADDR, 32'h3);
        rd(`CTRL_ADDR, 32'h7);
        feed(8'h05);
        wr(`CTRL_ADDR, 32'h2);
        wr(`CTRL_ADDR, 32'h5);
        rd(`CTRL_ADDR, 32'h2);
        feed(8'h06);
        wr(`CTRL_ADDR, 32'h6);
        rd(`CTRL_ADDR, 32'h2);
        feed(8'h05);
        repeat (WIN + 5) @(posedge ref_clk);
        wr(`CTRL_ADDR, 32'h6);
        rd(`CTRL_ADDR, 32'h2);
        feed(8'h05);
        repeat (WIN - 8) @(posedge ref_clk);
        wr(`CTRL_ADDR, 32'h3);
        rd(`CTRL_ADDR, 32'h3);
        $display("test window done");
        feed(8'h05);
        wr(`CTRL_ADDR, 32'h1);
        fireIn(P1 - 15, P1 + 5);
        repeat (P1 / 2) @(negedge ref_clk);
        @(posedge ref_clk);
        feed(8'h05);
        fireIn(P1 - 15, P1 + 5);
        repeat (P1 / 2) @(negedge ref_clk);
        @(posedge ref_clk);
        feed(8'h06);
        fireIn(P1 / 2 - 15, P1 / 2 + 5);
        $display("test timeout done");
        @(posedge ref_clk);
        feed(8'h05);
        wr(`CTRL_ADDR, 32'h4);
        waitFire(P1 + 200);
        check("reserved code", n, P1 + 200);
        $display("test reserved done");
        results();
    end
endmodule
